// ### hw/dpll_loop_param_pkg.sv
// Package with register map, field layout, reset values and encodings of the loop parameter block.
package dpll_loop_param_pkg;
	localparam logic [7:0] ADDR_AUX_PLL_LOOP_CFG2 = 8'h6a;
	localparam logic [7:0] ADDR_MAIN_PLL_LOOP_CFG2 = 8'h6b;
	localparam logic [7:0] ADDR_AUX_PLL_PD_GAIN_CFG = 8'h6c;
	localparam logic [7:0] ADDR_MAIN_PLL_PD_GAIN_CFG = 8'h6d;

	localparam logic [7:0] RST_LOOP_CFG2 = 8'h13;
	localparam logic [7:0] RST_PD_GAIN_CFG = 8'hc2;
	localparam logic [7:0] MASK_LOOP_CFG2 = 8'h77;
	localparam logic [7:0] MASK_PD_GAIN_CFG = 8'hf7;

	localparam int DAMPING_CODE_LSB = 0;
	localparam int GAIN_ANALOG_LOWRATE_LSB = 4;
	localparam int GAIN_DIGITAL_LSB = 0;
	localparam int GAIN_ANALOG_LSB = 4;
	localparam int AUTO_GAIN_ENABLE_BIT = 7;

	localparam logic [2:0] MAIN_FREQ_DIGITAL_FB = 3'h0;
	localparam logic [2:0] MAIN_FREQ_ANALOG_FB = 3'h1;

	localparam logic [1:0] AUX_BW_18HZ = 2'h0;
	localparam logic [1:0] AUX_BW_35HZ = 2'h1;
	localparam logic [1:0] AUX_BW_70HZ = 2'h2;

	localparam logic [4:0] MAIN_BW_4HZ = 5'h0d;
	localparam logic [4:0] MAIN_BW_8HZ = 5'h0e;
	localparam logic [4:0] MAIN_BW_18HZ = 5'h0f;
	localparam logic [4:0] MAIN_BW_35HZ = 5'h10;
	localparam logic [4:0] MAIN_BW_70HZ = 5'h11;

	localparam logic [2:0] DAMPING_CODE_CODE_1 = 3'h1;
	localparam logic [2:0] DAMPING_CODE_CODE_2 = 3'h2;
	localparam logic [2:0] DAMPING_CODE_CODE_3 = 3'h3;
	localparam logic [2:0] DAMPING_CODE_CODE_4 = 3'h4;
	localparam logic [2:0] DAMPING_CODE_CODE_5 = 3'h5;

	// Gain peaking in hundredths of a dB.
	localparam logic [5:0] PEAK_DF_1P2 = 6'h28;
	localparam logic [5:0] PEAK_DF_2P5 = 6'h14;
	localparam logic [5:0] PEAK_DF_5 = 6'h0a;
	localparam logic [5:0] PEAK_DF_10 = 6'h06;
	localparam logic [5:0] PEAK_DF_20 = 6'h03;

	typedef enum logic [2:0] {BW_COL_LE4, BW_COL_8, BW_COL_18, BW_COL_35, BW_COL_70} bw_col_t;
	typedef enum logic [2:0] {DF_1P2, DF_2P5, DF_5, DF_10, DF_20} damping_t;
endpackage

// ### hw/damping_decode.sv
// Combinational damping factor and gain peaking decoder for one loop.
`timescale 1ns/100ps
module damping_decode (
	input wire logic [2:0] i_damping_code,
	input dpll_loop_param_pkg::bw_col_t i_bw_col,
	output dpll_loop_param_pkg::damping_t o_damping,
	output logic [5:0] o_gain_peak
);
	always_comb begin
		o_damping = dpll_loop_param_pkg::DF_5;
		// Undefined codes fall back to the reset damping of 5.
		case (i_damping_code)
			dpll_loop_param_pkg::DAMPING_CODE_CODE_1: begin
				if (i_bw_col == dpll_loop_param_pkg::BW_COL_LE4) begin
					o_damping = dpll_loop_param_pkg::DF_5;
				end else if (i_bw_col == dpll_loop_param_pkg::BW_COL_8) begin
					o_damping = dpll_loop_param_pkg::DF_2P5;
				end else begin
					o_damping = dpll_loop_param_pkg::DF_1P2;
				end
			end
			dpll_loop_param_pkg::DAMPING_CODE_CODE_2: begin
				if (i_bw_col == dpll_loop_param_pkg::BW_COL_LE4 || i_bw_col == dpll_loop_param_pkg::BW_COL_8) begin
					o_damping = dpll_loop_param_pkg::DF_5;
				end else begin
					o_damping = dpll_loop_param_pkg::DF_2P5;
				end
			end
			dpll_loop_param_pkg::DAMPING_CODE_CODE_4: begin
				if (i_bw_col == dpll_loop_param_pkg::BW_COL_35 || i_bw_col == dpll_loop_param_pkg::BW_COL_70) begin
					o_damping = dpll_loop_param_pkg::DF_10;
				end
			end
			dpll_loop_param_pkg::DAMPING_CODE_CODE_5: begin
				if (i_bw_col == dpll_loop_param_pkg::BW_COL_35) begin
					o_damping = dpll_loop_param_pkg::DF_10;
				end else if (i_bw_col == dpll_loop_param_pkg::BW_COL_70) begin
					o_damping = dpll_loop_param_pkg::DF_20;
				end
			end
			default: begin
				o_damping = dpll_loop_param_pkg::DF_5;
			end
		endcase
	end

	always_comb begin
		case (o_damping)
			dpll_loop_param_pkg::DF_1P2: o_gain_peak = dpll_loop_param_pkg::PEAK_DF_1P2;
			dpll_loop_param_pkg::DF_2P5: o_gain_peak = dpll_loop_param_pkg::PEAK_DF_2P5;
			dpll_loop_param_pkg::DF_10: o_gain_peak = dpll_loop_param_pkg::PEAK_DF_10;
			dpll_loop_param_pkg::DF_20: o_gain_peak = dpll_loop_param_pkg::PEAK_DF_20;
			default: o_gain_peak = dpll_loop_param_pkg::PEAK_DF_5;
		endcase
	end
endmodule

// ### hw/dpll_loop_param_config.sv
// Loop parameter registers and damping and phase detector gain selection for the main and auxiliary loops.
`timescale 1ns/100ps
module dpll_loop_param_config (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic [2:0] i_main_loop_freq_sel,
	input wire logic i_aux_loop_digital_feedback_sel,
	input wire logic [1:0] i_aux_loop_bandwidth,
	input wire logic [4:0] i_main_loop_acq_bandwidth,
	input wire logic [4:0] i_main_loop_locked_bandwidth,
	input wire logic i_main_loop_acquiring,
	input wire logic i_main_input_le_8khz,
	input wire logic i_aux_input_le_8khz,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output dpll_loop_param_pkg::damping_t o_main_damping,
	output logic [5:0] o_main_gain_peak,
	output dpll_loop_param_pkg::damping_t o_aux_damping,
	output logic [5:0] o_aux_gain_peak,
	output logic o_main_pd_second_enable,
	output logic [2:0] o_main_pd_second_gain,
	output logic o_aux_pd_second_enable,
	output logic [2:0] o_aux_pd_second_gain
);
	logic [7:0] aux_pll_loop_cfg2_ff;
	logic [7:0] main_pll_loop_cfg2_ff;
	logic [7:0] aux_pll_pd_gain_cfg_ff;
	logic [7:0] main_pll_pd_gain_cfg_ff;
	logic [7:0] nxt_rd_data;
	logic [4:0] main_bw;
	dpll_loop_param_pkg::bw_col_t main_bw_col;
	dpll_loop_param_pkg::bw_col_t aux_bw_col;
	dpll_loop_param_pkg::damping_t main_damping;
	dpll_loop_param_pkg::damping_t aux_damping;
	logic [5:0] main_peak;
	logic [5:0] aux_peak;
	logic main_digital_fb;
	logic [2:0] nxt_main_gain;
	logic [2:0] nxt_aux_gain;

	// Register writes; unused bits are masked so they read as zero.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			aux_pll_loop_cfg2_ff <= dpll_loop_param_pkg::RST_LOOP_CFG2;
			main_pll_loop_cfg2_ff <= dpll_loop_param_pkg::RST_LOOP_CFG2;
			aux_pll_pd_gain_cfg_ff <= dpll_loop_param_pkg::RST_PD_GAIN_CFG;
			main_pll_pd_gain_cfg_ff <= dpll_loop_param_pkg::RST_PD_GAIN_CFG;
		end else if (i_wr_en) begin
			if (i_addr == dpll_loop_param_pkg::ADDR_AUX_PLL_LOOP_CFG2) begin
				aux_pll_loop_cfg2_ff <= i_wr_data & dpll_loop_param_pkg::MASK_LOOP_CFG2;
			end else if (i_addr == dpll_loop_param_pkg::ADDR_MAIN_PLL_LOOP_CFG2) begin
				main_pll_loop_cfg2_ff <= i_wr_data & dpll_loop_param_pkg::MASK_LOOP_CFG2;
			end else if (i_addr == dpll_loop_param_pkg::ADDR_AUX_PLL_PD_GAIN_CFG) begin
				aux_pll_pd_gain_cfg_ff <= i_wr_data & dpll_loop_param_pkg::MASK_PD_GAIN_CFG;
			end else if (i_addr == dpll_loop_param_pkg::ADDR_MAIN_PLL_PD_GAIN_CFG) begin
				main_pll_pd_gain_cfg_ff <= i_wr_data & dpll_loop_param_pkg::MASK_PD_GAIN_CFG;
			end
		end
	end

	always_comb begin
		if (i_addr == dpll_loop_param_pkg::ADDR_AUX_PLL_LOOP_CFG2) begin
			nxt_rd_data = aux_pll_loop_cfg2_ff;
		end else if (i_addr == dpll_loop_param_pkg::ADDR_MAIN_PLL_LOOP_CFG2) begin
			nxt_rd_data = main_pll_loop_cfg2_ff;
		end else if (i_addr == dpll_loop_param_pkg::ADDR_AUX_PLL_PD_GAIN_CFG) begin
			nxt_rd_data = aux_pll_pd_gain_cfg_ff;
		end else if (i_addr == dpll_loop_param_pkg::ADDR_MAIN_PLL_PD_GAIN_CFG) begin
			nxt_rd_data = main_pll_pd_gain_cfg_ff;
		end else begin
			nxt_rd_data = 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_data <= i_rd_en ? nxt_rd_data : 8'h00;
			o_rd_valid <= i_rd_en;
		end
	end

	assign main_bw = i_main_loop_acquiring ? i_main_loop_acq_bandwidth : i_main_loop_locked_bandwidth;

	always_comb begin
		if (main_bw == dpll_loop_param_pkg::MAIN_BW_8HZ) begin
			main_bw_col = dpll_loop_param_pkg::BW_COL_8;
		end else if (main_bw == dpll_loop_param_pkg::MAIN_BW_18HZ) begin
			main_bw_col = dpll_loop_param_pkg::BW_COL_18;
		end else if (main_bw == dpll_loop_param_pkg::MAIN_BW_35HZ) begin
			main_bw_col = dpll_loop_param_pkg::BW_COL_35;
		end else if (main_bw == dpll_loop_param_pkg::MAIN_BW_70HZ) begin
			main_bw_col = dpll_loop_param_pkg::BW_COL_70;
		end else begin
			main_bw_col = dpll_loop_param_pkg::BW_COL_LE4;
		end
	end

	always_comb begin
		if (i_aux_loop_bandwidth == dpll_loop_param_pkg::AUX_BW_35HZ) begin
			aux_bw_col = dpll_loop_param_pkg::BW_COL_35;
		end else if (i_aux_loop_bandwidth == dpll_loop_param_pkg::AUX_BW_70HZ) begin
			aux_bw_col = dpll_loop_param_pkg::BW_COL_70;
		end else begin
			aux_bw_col = dpll_loop_param_pkg::BW_COL_18;
		end
	end

	damping_decode u_main_damping (
		.i_damping_code(main_pll_loop_cfg2_ff[dpll_loop_param_pkg::DAMPING_CODE_LSB +: 3]),
		.i_bw_col(main_bw_col),
		.o_damping(main_damping),
		.o_gain_peak(main_peak)
	);

	damping_decode u_aux_damping (
		.i_damping_code(aux_pll_loop_cfg2_ff[dpll_loop_param_pkg::DAMPING_CODE_LSB +: 3]),
		.i_bw_col(aux_bw_col),
		.o_damping(aux_damping),
		.o_gain_peak(aux_peak)
	);

	// Only the analog 77.76 MHz code selects analog feedback for the main loop.
	assign main_digital_fb = (i_main_loop_freq_sel != dpll_loop_param_pkg::MAIN_FREQ_ANALOG_FB);

	always_comb begin
		nxt_main_gain = 3'h0;
		if (main_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::AUTO_GAIN_ENABLE_BIT]) begin
			if (main_digital_fb) begin
				nxt_main_gain = main_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::GAIN_DIGITAL_LSB +: 3];
			end else if (i_main_input_le_8khz) begin
				nxt_main_gain = main_pll_loop_cfg2_ff[dpll_loop_param_pkg::GAIN_ANALOG_LOWRATE_LSB +: 3];
			end else begin
				nxt_main_gain = main_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::GAIN_ANALOG_LSB +: 3];
			end
		end
	end

	always_comb begin
		nxt_aux_gain = 3'h0;
		if (aux_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::AUTO_GAIN_ENABLE_BIT]) begin
			if (i_aux_loop_digital_feedback_sel) begin
				nxt_aux_gain = aux_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::GAIN_DIGITAL_LSB +: 3];
			end else if (i_aux_input_le_8khz) begin
				nxt_aux_gain = aux_pll_loop_cfg2_ff[dpll_loop_param_pkg::GAIN_ANALOG_LOWRATE_LSB +: 3];
			end else begin
				nxt_aux_gain = aux_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::GAIN_ANALOG_LSB +: 3];
			end
		end
	end

	// Loop-facing outputs are registered one cycle after the register or mode input changes.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_main_damping <= dpll_loop_param_pkg::DF_5;
			o_main_gain_peak <= dpll_loop_param_pkg::PEAK_DF_5;
			o_aux_damping <= dpll_loop_param_pkg::DF_5;
			o_aux_gain_peak <= dpll_loop_param_pkg::PEAK_DF_5;
			o_main_pd_second_enable <= 1'b0;
			o_main_pd_second_gain <= 3'h0;
			o_aux_pd_second_enable <= 1'b0;
			o_aux_pd_second_gain <= 3'h0;
		end else begin
			o_main_damping <= main_damping;
			o_main_gain_peak <= main_peak;
			o_aux_damping <= aux_damping;
			o_aux_gain_peak <= aux_peak;
			o_main_pd_second_enable <= main_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::AUTO_GAIN_ENABLE_BIT];
			o_main_pd_second_gain <= nxt_main_gain;
			o_aux_pd_second_enable <= aux_pll_pd_gain_cfg_ff[dpll_loop_param_pkg::AUTO_GAIN_ENABLE_BIT];
			o_aux_pd_second_gain <= nxt_aux_gain;
		end
	end
endmodule

// ### test/dpll_loop_param_asserts.sv
// Concurrent checks on the ports of the loop parameter block.
`timescale 1ns/100ps
module dpll_loop_param_asserts (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_main_loop_acquiring,
	input wire logic [4:0] i_main_loop_acq_bandwidth,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_valid,
	input dpll_loop_param_pkg::damping_t o_main_damping,
	input wire logic [5:0] o_main_gain_peak,
	input wire logic o_main_pd_second_enable,
	input wire logic [2:0] o_main_pd_second_gain,
	input wire logic o_aux_pd_second_enable,
	input wire logic [2:0] o_aux_pd_second_gain
);
	localparam logic [5:0] PK [5] = '{6'h28, 6'h14, 6'h0a, 6'h06, 6'h03};
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	property p_rd_ans; i_rd_en |=> o_rd_valid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_idle; !i_rd_en |=> !o_rd_valid && o_rd_data == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_rd_unmap; i_rd_en && (i_addr < 8'h6a || i_addr > 8'h6d) |=> o_rd_data == 8'h00; endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
	property p_main_off; !o_main_pd_second_enable |-> o_main_pd_second_gain == 3'h0; endproperty
	a_main_off: assert property (p_main_off) else $error("main gain while disabled");
	property p_aux_off; !o_aux_pd_second_enable |-> o_aux_pd_second_gain == 3'h0; endproperty
	a_aux_off: assert property (p_aux_off) else $error("aux gain while disabled");
	property p_main_peak; o_main_gain_peak == PK[o_main_damping]; endproperty
	a_main_peak: assert property (p_main_peak) else $error("main peak wrong");
	property p_main_wr;
		i_wr_en && i_addr == 8'h6d |-> ##2 o_main_pd_second_enable == $past(i_wr_data[7], 2); endproperty
	a_main_wr: assert property (p_main_wr) else $error("main enable not applied");
	property p_aux_wr;
		i_wr_en && i_addr == 8'h6c |-> ##2 o_aux_pd_second_enable == $past(i_wr_data[7], 2); endproperty
	a_aux_wr: assert property (p_aux_wr) else $error("aux enable not applied");
	property p_acq4; i_main_loop_acquiring && i_main_loop_acq_bandwidth == 5'h0d
		|=> o_main_damping == dpll_loop_param_pkg::DF_5; endproperty
	a_acq4: assert property (p_acq4) else $error("main damping at 4 Hz not 5");
	c_read: cover property (i_rd_en && i_addr == 8'h6d);
	c_main_gain: cover property (o_main_pd_second_enable && o_main_pd_second_gain != 3'h0);
	c_aux_gain: cover property (o_aux_pd_second_enable && o_aux_pd_second_gain != 3'h0);
endmodule

bind dpll_loop_param_config dpll_loop_param_asserts u_chk (.i_ref_clk, .i_srst, .i_wr_en, .i_rd_en, .i_addr,
	.i_wr_data, .i_main_loop_acquiring, .i_main_loop_acq_bandwidth, .o_rd_data, .o_rd_valid, .o_main_damping,
	.o_main_gain_peak, .o_main_pd_second_enable, .o_main_pd_second_gain, .o_aux_pd_second_enable,
	.o_aux_pd_second_gain);

// ### test/tb.sv
// Randomised self-checking bench for the loop parameter block.
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, srst = 1'b1, we = 1'b0, re = 1'b0, acq = 1'b0, dfb = 1'b0, ml8 = 1'b0, al8 = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdd, wa;
	logic [2:0] fs = 3'h0, mg, ag;
	logic [1:0] abw = 2'h0;
	logic [4:0] mab = 5'h0d, mlb = 5'h0d;
	logic rv, men, aen;
	logic [5:0] mpk, apk;
	dpll_loop_param_pkg::damping_t md, ad;
	logic [7:0] m [4];
	logic [31:0] s = 32'h15, r;
	int fail_count = 0, total_checks = 0;
	localparam logic [5:0] PK [5] = '{6'h28, 6'h14, 6'h0a, 6'h06, 6'h03};
	dpll_loop_param_config DUT (.i_ref_clk(clk), .i_srst(srst), .i_wr_en(we), .i_rd_en(re), .i_addr(addr),
		.i_wr_data(wd), .i_main_loop_freq_sel(fs), .i_aux_loop_digital_feedback_sel(dfb), .i_aux_loop_bandwidth(abw),
		.i_main_loop_acq_bandwidth(mab), .i_main_loop_locked_bandwidth(mlb), .i_main_loop_acquiring(acq),
		.i_main_input_le_8khz(ml8), .i_aux_input_le_8khz(al8), .o_rd_data(rdd), .o_rd_valid(rv),
		.o_main_damping(md), .o_main_gain_peak(mpk), .o_aux_damping(ad), .o_aux_gain_peak(apk),
		.o_main_pd_second_enable(men), .o_main_pd_second_gain(mg), .o_aux_pd_second_enable(aen),
		.o_aux_pd_second_gain(ag));
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [2:0] df(input logic [2:0] c, input logic [2:0] col);
		if (c == 3'h0 || c > 3'h5 || col == 3'h0) return 3'h2;
		if (col == 3'h1) return (c == 3'h1) ? 3'h1 : 3'h2;
		if (c < 3'h4) return c - 3'h1;
		if (col == 3'h2) return 3'h2;
		return (c == 3'h5 && col == 3'h4) ? 3'h4 : 3'h3;
	endfunction
	// Software never programs the undefined damping codes, so random data is steered onto defined ones.
	function automatic logic [7:0] keep_damping_code(input logic [7:0] a, input logic [7:0] d);
		if (a[1] && (d[2:0] == 3'h0 || d[2:0] > 3'h5)) return {d[7:3], 3'h1 + 3'(d[1:0])};
		return d;
	endfunction
	function automatic logic [2:0] mc(input logic [4:0] b);
		return (b >= 5'h0e && b <= 5'h11) ? 3'(b - 5'h0d) : 3'h0;
	endfunction
	function automatic logic [2:0] gn(input logic [7:0] c2, input logic [7:0] pd, input logic dig, input logic l8);
		if (!pd[7]) return 3'h0;
		return dig ? pd[2:0] : (l8 ? c2[6:4] : pd[6:4]);
	endfunction
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{we, addr, wd} = {1'b1, a, d};
		@(negedge clk);
		we = 1'b0;
		if (a >= 8'h6a && a <= 8'h6d) m[2'(a - 8'h6a)] = d & (a[1] ? 8'h77 : 8'hf7);
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		{re, addr} = {1'b1, a};
		@(negedge clk);
		re = 1'b0;
		ck(8'(rv), 8'h01);
		ck(rdd, (a >= 8'h6a && a <= 8'h6d) ? m[2'(a - 8'h6a)] : 8'h00);
	endtask
	task automatic mode();
		logic [31:0] q;
		q = rnd();
		{acq, dfb, ml8, al8, fs, abw} = q[8:0];
		mab = 5'h0c + 5'(q[11:9]);
		mlb = 5'h0c + 5'(q[14:12]);
	endtask
	task automatic chk();
		logic [2:0] em, ea;
		@(negedge clk);
		em = df(m[1][2:0], mc(acq ? mab : mlb));
		ea = df(m[0][2:0], (abw == 2'h3) ? 3'h2 : 3'(abw) + 3'h2);
		ck(8'(md), 8'(em));
		ck(8'(mpk), 8'(PK[em]));
		ck(8'(ad), 8'(ea));
		ck(8'(apk), 8'(PK[ea]));
		ck(8'(men), 8'(m[3][7]));
		ck(8'(mg), 8'(gn(m[1], m[3], fs != 3'h1, ml8)));
		ck(8'(aen), 8'(m[2][7]));
		ck(8'(ag), 8'(gn(m[0], m[2], dfb, al8)));
	endtask
	task automatic rst(input int n);
		@(negedge clk);
		srst = 1'b1;
		repeat (n) @(negedge clk);
		srst = 1'b0;
		m = '{8'h13, 8'h13, 8'hc2, 8'hc2};
		for (int i = 0; i < 7; i++) rd(8'h69 + 8'(i));
		chk();
	endtask
	task automatic close_out();
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	initial begin
		rst(16);
		for (int c = 0; c < 8; c++) begin
			wr(8'h6a, 8'(c % 5 + 1) | 8'h88);
			wr(8'h6b, 8'(c % 5 + 1) | 8'h88);
			repeat (16) begin
				mode();
				chk();
			end
		end
		repeat (300) begin
			r = rnd();
			wa = 8'h6a + 8'({r[2] & r[3], r[1:0]});
			wr(wa, keep_damping_code(wa, r[15:8]));
			mode();
			chk();
			rd(8'h6a + 8'(r[5:4]));
		end
		rst(2);
		close_out();
	end
endmodule
